// *** logic/mivu_top.sv ***
/*
  Interrupt vector unit: factor flags, masks, key comparison registers and
  the vector presented to the CPU core, reached as I/O memory.
  Assumes the CPU core issues at most one read or write per cycle, that
  event inputs are one-cycle pulses, and that all inputs are synchronous.
*/
// Overview of operation
// RQ1: Reset starts execution at page 1 step 00.
// RQ2: Vectors load page 1 steps 01 to 0F.
// RQ3: Push next address, then load vector, then run.
// RQ4: Save and vector load take twelve cycles.
// RQ5: Vector bits: lap, tick, key, serial requests.
// RQ6: Timer flags at 2E9, bit 3 zero.
// RQ7: Factor flags clear on read and reset.
// RQ8: Tick enables at 2E8, reset to zero.
// RQ9: Lap enables at 2E6, reset to zero.
// RQ10: Lap and key flags at 2EA, read only.
// RQ11: Key group enables at 2E5, reset zero.
// RQ12: Key group compare bits at 2E4, reset zero.
// RQ13: 2E3 returns live key group levels.
// RQ14: 2E7 holds key line level, compare, enable.
// RQ15: Write-only triggers always read back zero.
// RQ16: Enabled key changing away from compare flags.
// RQ17: Request while any enabled flag is set.
// RQ18: Handler reads flags to withdraw its request.
module mivu_top
  import mivu_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic [11:0] i_mem_addr,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_wr,
  input  wire logic [3:0]  i_mem_wdata,
  output logic [3:0]       o_mem_rdata,
  input  wire logic        i_fast_tick,
  input  wire logic        i_mid_tick,
  input  wire logic        i_slow_tick,
  input  wire logic        i_lap_tenth,
  input  wire logic        i_lap_second,
  input  wire logic [3:0]  i_keygrp0_level,
  input  wire logic        i_keyline10_level,
  input  wire logic        i_keygrp2_request,
  input  wire logic        i_serial_request,
  input  wire logic        i_sub_bld_low,
  input  wire logic        i_interrupt_flag,
  input  wire logic        i_instr_done,
  input  wire logic [11:0] i_pc_next,
  output logic             o_irq_request,
  output logic             o_stack_push,
  output logic [11:0]      o_stack_data,
  output logic             o_pc_load,
  output logic [11:0]      o_pc_value,
  output logic             o_busy,
  output logic             o_heavy_load_mode,
  output logic             o_lcd_static_select,
  output logic             o_serial_clock_trigger,
  output logic             o_tick_counter_clear,
  output logic             o_lap_counter_clear
);

  // ********************************************************************
  // Decode
  // ********************************************************************
  logic wr_compare, wr_enable, wr_load_lap, wr_key10, wr_lcd_tick;
  logic wr_clear, rd_timer_flags, rd_key_lap_flags;

  assign wr_compare  = i_mem_wr & (i_mem_addr == ADDR_KEYGRP0_COMPARE);
  assign wr_enable   = i_mem_wr & (i_mem_addr == ADDR_KEYGRP0_ENABLE);
  assign wr_load_lap = i_mem_wr & (i_mem_addr == ADDR_LOAD_LAP_ENABLE);
  assign wr_key10    = i_mem_wr & (i_mem_addr == ADDR_KEY10_CONTROL);
  assign wr_lcd_tick = i_mem_wr & (i_mem_addr == ADDR_LCD_TICK_ENABLE);
  assign wr_clear    = i_mem_wr & (i_mem_addr == ADDR_COUNTER_CLEAR);
  assign rd_timer_flags   = i_mem_rd & (i_mem_addr == ADDR_TIMER_FLAGS);
  assign rd_key_lap_flags = i_mem_rd & (i_mem_addr == ADDR_KEY_LAP_FLAGS);

  // ********************************************************************
  // Control registers
  // ********************************************************************
  logic [3:0] keygrp0_compare_r;
  logic [3:0] keygrp0_enable_r;
  logic [1:0] lap_enable_r;
  logic       heavy_load_mode_r;
  logic       keyline10_compare_r;
  logic       keyline10_enable_r;
  logic [2:0] tick_enable_r;
  logic       lcd_static_select_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      keygrp0_compare_r <= NIBBLE_RESET; // [RQ12]
      keygrp0_enable_r  <= NIBBLE_RESET; // [RQ11]
    end else begin
      if (wr_compare) begin
        keygrp0_compare_r <= i_mem_wdata; // [RQ12]
      end
      if (wr_enable) begin
        keygrp0_enable_r <= i_mem_wdata; // [RQ11]
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      lap_enable_r      <= 2'b00; // [RQ9]
      heavy_load_mode_r <= 1'b0;
    end else if (wr_load_lap) begin
      lap_enable_r      <= i_mem_wdata[BIT_LAP_SECOND:BIT_LAP_TENTH]; // [RQ9]
      heavy_load_mode_r <= i_mem_wdata[BIT_HEAVY_LOAD];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      keyline10_compare_r <= 1'b0; // [RQ14]
      keyline10_enable_r  <= 1'b0;
    end else if (wr_key10) begin
      keyline10_compare_r <= i_mem_wdata[BIT_KEY10_COMPARE]; // [RQ14]
      keyline10_enable_r  <= i_mem_wdata[BIT_KEY10_ENABLE];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tick_enable_r       <= 3'b000; // [RQ8]
      lcd_static_select_r <= 1'b0;
    end else if (wr_lcd_tick) begin
      tick_enable_r       <= i_mem_wdata[BIT_SLOW_TICK:BIT_FAST_TICK]; // [RQ8]
      lcd_static_select_r <= i_mem_wdata[BIT_LCD_STATIC];
    end
  end

  // Trigger bits hold no state, so nothing of them can be read back.
  assign o_serial_clock_trigger = wr_key10 & i_mem_wdata[BIT_SERIAL_TRIG];
  assign o_tick_counter_clear   = wr_clear & i_mem_wdata[BIT_TICK_CLEAR];
  assign o_lap_counter_clear    = wr_clear & i_mem_wdata[BIT_LAP_CLEAR];
  assign o_heavy_load_mode      = heavy_load_mode_r;
  assign o_lcd_static_select    = lcd_static_select_r;

  // ********************************************************************
  // Key change detection
  // ********************************************************************
  logic keygrp0_hit, keyline10_hit;

  mivu_key_detect #(.N(4)) u_keygrp0 (
    .i_clock   (i_clock),
    .i_srst    (i_srst),
    .i_level   (i_keygrp0_level),
    .i_compare (keygrp0_compare_r),
    .i_enable  (keygrp0_enable_r),
    .o_hit     (keygrp0_hit)
  );

  mivu_key_detect #(.N(1)) u_keyline10 (
    .i_clock   (i_clock),
    .i_srst    (i_srst),
    .i_level   (i_keyline10_level),
    .i_compare (keyline10_compare_r),
    .i_enable  (keyline10_enable_r),
    .o_hit     (keyline10_hit)
  );

  // ********************************************************************
  // Factor flags
  // ********************************************************************
  // An event in the cycle of the clearing read survives that read, so a
  // tick is never lost; the handler then sees it on its next read.
  logic [2:0] tick_flag_r;
  logic [3:0] key_lap_flag_r;
  logic [2:0] tick_events;
  logic [3:0] key_lap_events;

  assign tick_events = {i_slow_tick, i_mid_tick, i_fast_tick};
  assign key_lap_events = {keyline10_hit, keygrp0_hit,
                           i_lap_second, i_lap_tenth};

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tick_flag_r <= 3'b000; // [RQ7]
    end else begin
      tick_flag_r <= (rd_timer_flags ? 3'b000 : tick_flag_r) |
                     tick_events; // [RQ6] [RQ7]
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      key_lap_flag_r <= NIBBLE_RESET; // [RQ7]
    end else begin
      key_lap_flag_r <= (rd_key_lap_flags ? NIBBLE_RESET : key_lap_flag_r) |
                        key_lap_events; // [RQ10] [RQ7]
    end
  end

  // ********************************************************************
  // Request and vector
  // ********************************************************************
  logic       lap_pending, tick_pending, key_pending;
  logic [3:0] vector;

  assign lap_pending  = |(key_lap_flag_r[BIT_LAP_SECOND:BIT_LAP_TENTH] &
                          lap_enable_r);
  assign tick_pending = |(tick_flag_r & tick_enable_r);
  // Key flags are only ever set through an enabled input.
  assign key_pending  = key_lap_flag_r[BIT_KEYGRP0_FLAG] |
                        key_lap_flag_r[BIT_KEY10_FLAG] | i_keygrp2_request;

  always_comb begin
    vector             = 4'h0;
    vector[VEC_LAP]    = lap_pending; // [RQ5]
    vector[VEC_TICK]   = tick_pending;
    vector[VEC_KEY]    = key_pending;
    vector[VEC_SERIAL] = i_serial_request;
  end

  // Flag requests drop once the handler has read the flags; serial and key group 2 requests follow their inputs. [RQ18]
  assign o_irq_request = |vector; // [RQ17]

  mivu_vector_seq u_seq (
    .i_clock      (i_clock),
    .i_srst       (i_srst),
    .i_request    (o_irq_request),
    .i_vector     (vector),
    .i_accept_ok  (i_interrupt_flag & i_instr_done), // [RQ3]
    .i_pc_next    (i_pc_next),
    .o_stack_push (o_stack_push),
    .o_stack_data (o_stack_data),
    .o_pc_load    (o_pc_load),
    .o_pc_value   (o_pc_value),
    .o_busy       (o_busy)
  );

  // ********************************************************************
  // Read data
  // ********************************************************************
  logic [3:0] rdata_nxt;
  logic [3:0] rdata_r;

  always_comb begin
    rdata_nxt = 4'h0;
    unique case (i_mem_addr)
      ADDR_KEYGRP0_LEVELS:  rdata_nxt = i_keygrp0_level; // [RQ13]
      ADDR_KEYGRP0_COMPARE: rdata_nxt = keygrp0_compare_r;
      ADDR_KEYGRP0_ENABLE:  rdata_nxt = keygrp0_enable_r;
      ADDR_LOAD_LAP_ENABLE: rdata_nxt = {heavy_load_mode_r, i_sub_bld_low,
                                         lap_enable_r};
      ADDR_KEY10_CONTROL:   rdata_nxt = {1'b0, keyline10_enable_r,
                                         keyline10_compare_r,
                                         i_keyline10_level}; // [RQ14] [RQ15]
      ADDR_LCD_TICK_ENABLE: rdata_nxt = {lcd_static_select_r, tick_enable_r};
      ADDR_TIMER_FLAGS:     rdata_nxt = {1'b0, tick_flag_r}; // [RQ6]
      ADDR_KEY_LAP_FLAGS:   rdata_nxt = key_lap_flag_r; // [RQ10]
      ADDR_COUNTER_CLEAR:   rdata_nxt = 4'h0; // [RQ15]
      default:              rdata_nxt = 4'h0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_r <= 4'h0;
    end else if (i_mem_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_mem_rdata = rdata_r;

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_tick_flag_set: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ6]
    i_fast_tick |=> tick_flag_r[BIT_FAST_TICK])
    else $error("fast tick did not set its flag");

  a_read_clears: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ7]
    (rd_key_lap_flags && key_lap_events == 4'h0) |=>
      (key_lap_flag_r == 4'h0 && o_mem_rdata == $past(key_lap_flag_r)))
    else $error("flag read did not return and clear flags");

  a_timer_top_zero: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ6]
    rd_timer_flags |=> (o_mem_rdata[3] == 1'b0 &&
      o_mem_rdata[2:0] == $past(tick_flag_r)))
    else $error("timer flag readout wrong");

  a_tick_mask_gate: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ8]
    (wr_lcd_tick && i_mem_wdata[2:0] == 3'b000) ##1
      (!i_serial_request && !lap_pending && !key_pending && !wr_lcd_tick)
      |-> !o_irq_request)
    else $error("masked tick flags still raise a request");

  a_lap_enable_wr: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ9]
    wr_load_lap |=> lap_enable_r == $past(i_mem_wdata[1:0]))
    else $error("lap enable write lost");

  a_key_flag_path: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ11]
    keygrp0_hit |=> (key_lap_flag_r[BIT_KEYGRP0_FLAG] && o_irq_request &&
      vector[VEC_KEY]))
    else $error("key group change raised no key request");

  a_trigger_reads_zero: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ15]
    (i_mem_rd && (i_mem_addr == ADDR_KEY10_CONTROL ||
      i_mem_addr == ADDR_COUNTER_CLEAR)) |=> o_mem_rdata[3] == 1'b0)
    else $error("trigger bit read back nonzero");

  a_vector_serial: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ5]
    o_irq_request == (lap_pending || tick_pending || key_pending ||
      i_serial_request) && vector[VEC_SERIAL] == i_serial_request)
    else $error("request and vector bits disagree");

  a_reset_clears: assert property (@(posedge i_clock) // [RQ12]
    i_srst |=> (keygrp0_compare_r == 4'h0 && keygrp0_enable_r == 4'h0 &&
      tick_flag_r == 3'b000 && key_lap_flag_r == 4'h0))
    else $error("registers not cleared by reset");

  a_level_live: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ13]
    (i_mem_rd && i_mem_addr == ADDR_KEYGRP0_LEVELS) |=>
      o_mem_rdata == $past(i_keygrp0_level))
    else $error("live key levels not returned");

endmodule

// *** logic/mivu_pkg.sv ***
/*
  Package of the interrupt vector unit: I/O memory offsets, bit positions,
  reset values and the timing of interrupt acceptance.
  Assumes a 12-bit I/O memory address from the CPU core and 4-bit data.
*/
package mivu_pkg;

  // ********************************************************************
  // I/O memory offsets
  // ********************************************************************
  localparam logic [11:0] ADDR_KEYGRP0_LEVELS  = 12'h2E3;
  localparam logic [11:0] ADDR_KEYGRP0_COMPARE = 12'h2E4;
  localparam logic [11:0] ADDR_KEYGRP0_ENABLE  = 12'h2E5;
  localparam logic [11:0] ADDR_LOAD_LAP_ENABLE = 12'h2E6;
  localparam logic [11:0] ADDR_KEY10_CONTROL   = 12'h2E7;
  localparam logic [11:0] ADDR_LCD_TICK_ENABLE = 12'h2E8;
  localparam logic [11:0] ADDR_TIMER_FLAGS     = 12'h2E9;
  localparam logic [11:0] ADDR_KEY_LAP_FLAGS   = 12'h2EA;
  localparam logic [11:0] ADDR_COUNTER_CLEAR   = 12'h2EE;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_FAST_TICK     = 0;
  localparam int BIT_MID_TICK      = 1;
  localparam int BIT_SLOW_TICK     = 2;
  localparam int BIT_LAP_TENTH     = 0;
  localparam int BIT_LAP_SECOND    = 1;
  localparam int BIT_SUB_BLD       = 2;
  localparam int BIT_HEAVY_LOAD    = 3;
  localparam int BIT_KEYGRP0_FLAG  = 2;
  localparam int BIT_KEY10_FLAG    = 3;
  localparam int BIT_KEY10_LEVEL   = 0;
  localparam int BIT_KEY10_COMPARE = 1;
  localparam int BIT_KEY10_ENABLE  = 2;
  localparam int BIT_SERIAL_TRIG   = 3;
  localparam int BIT_LCD_STATIC    = 3;
  localparam int BIT_TICK_CLEAR    = 3;
  localparam int BIT_LAP_CLEAR     = 1;
  localparam int VEC_LAP           = 3;
  localparam int VEC_TICK          = 2;
  localparam int VEC_KEY           = 1;
  localparam int VEC_SERIAL        = 0;

  // ********************************************************************
  // Reset values and program counter constants
  // ********************************************************************
  localparam logic [3:0]  NIBBLE_RESET   = 4'h0;
  localparam logic [3:0]  VECTOR_PAGE    = 4'h1;
  localparam logic [3:0]  VECTOR_STEP_HI = 4'h0;
  localparam logic [11:0] PC_RESET_VALUE = 12'h100;

  // ********************************************************************
  // Interrupt acceptance timing in system clock cycles
  // ********************************************************************
  localparam int          ACCEPT_CYCLES = 12;
  localparam logic [3:0]  ACCEPT_LAST   = 4'(ACCEPT_CYCLES - 1);

  typedef enum logic [1:0] {
    SEQ_BOOT,
    SEQ_IDLE,
    SEQ_SAVE
  } mivu_seq_state_t;

endpackage

// *** logic/mivu_key_detect.sv ***
/*
  Change detector for a group of key inputs against comparison bits.
  Assumes inputs synchronous to i_clock and held stable between edges.
*/
module mivu_key_detect
  import mivu_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  input  wire logic [N-1:0] i_level,
  input  wire logic [N-1:0] i_compare,
  input  wire logic [N-1:0] i_enable,
  output logic              o_hit
);

  logic [N-1:0] level_prev_r;
  logic [N-1:0] hit_bits;
  logic         armed_r;

  // The first sample after reset has no history, so it cannot trigger.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_bit
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          level_prev_r[g] <= 1'b0;
        end else begin
          level_prev_r[g] <= i_level[g];
        end
      end
      // A masked input or a change that matches its compare bit is ignored.
      assign hit_bits[g] = armed_r & i_enable[g] &
                           (i_level[g] != level_prev_r[g]) &
                           (i_level[g] != i_compare[g]); // [RQ16]
    end
  endgenerate

  assign o_hit = |hit_bits;

  a_key_change_hit: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ16]
    armed_r && $changed(i_level) && (((i_level ^ $past(i_level)) &
      (i_level ^ i_compare) & i_enable) != '0) |-> o_hit)
    else $error("key change against compare did not hit");

endmodule

// *** logic/mivu_vector_seq.sv ***
/*
  Boot start and interrupt acceptance sequencer: saves the next address,
  then loads the vector into the program counter.
  Assumes the CPU core stalls while o_busy is high and applies o_pc_value
  on the cycle that o_pc_load is high.
*/
module mivu_vector_seq
  import mivu_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_request,
  input  wire logic [3:0]  i_vector,
  input  wire logic        i_accept_ok,
  input  wire logic [11:0] i_pc_next,
  output logic             o_stack_push,
  output logic [11:0]      o_stack_data,
  output logic             o_pc_load,
  output logic [11:0]      o_pc_value,
  output logic             o_busy
);

  mivu_seq_state_t state_r;
  logic [3:0]      count_r;
  logic [11:0]     stack_data_r;
  logic [11:0]     pc_value_r;
  logic            accept;

  assign accept = (state_r == SEQ_IDLE) & i_request & i_accept_ok;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= SEQ_BOOT;
      count_r <= 4'h0;
    end else begin
      unique case (state_r)
        SEQ_BOOT: begin
          state_r <= SEQ_IDLE;
        end
        SEQ_IDLE: begin
          if (accept) begin
            state_r <= SEQ_SAVE;
            count_r <= 4'h0;
          end
        end
        SEQ_SAVE: begin
          count_r <= count_r + 4'h1;
          if (count_r == ACCEPT_LAST) begin // [RQ4]
            state_r <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // The vector is frozen at acceptance so that a flag read mid-sequence
  // cannot change the address already chosen.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pc_value_r   <= PC_RESET_VALUE; // [RQ1]
      stack_data_r <= 12'h000;
    end else if (accept) begin
      stack_data_r <= i_pc_next; // [RQ3]
      pc_value_r   <= {VECTOR_PAGE, VECTOR_STEP_HI, i_vector}; // [RQ2]
    end
  end

  assign o_stack_push = (state_r == SEQ_SAVE) & (count_r == 4'h0); // [RQ3]
  assign o_pc_load    = (state_r == SEQ_BOOT) |
                        ((state_r == SEQ_SAVE) & (count_r == ACCEPT_LAST));
  assign o_stack_data = stack_data_r;
  assign o_pc_value   = pc_value_r;
  assign o_busy       = (state_r == SEQ_SAVE);

  sequence s_accept;
    accept;
  endsequence

  sequence s_save_then_load;
    ##1 (o_stack_push && o_busy) ##1 (o_busy && !o_pc_load) [*5]
    ##1 (o_busy && !o_pc_load) [*5] ##1 (o_busy && o_pc_load) ##1 !o_busy;
  endsequence

  a_accept_twelve: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ4]
    s_accept |-> s_save_then_load)
    else $error("acceptance did not take twelve cycles");

  a_vector_range: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ2]
    (o_pc_load && state_r == SEQ_SAVE) |->
      (o_pc_value[11:4] == 8'h10 && o_pc_value[3:0] != 4'h0))
    else $error("vector outside page 1 steps 01 to 0F");

  a_boot_address: assert property (@(posedge i_clock) // [RQ1]
    $fell(i_srst) |-> (o_pc_load && o_pc_value == PC_RESET_VALUE))
    else $error("start address after reset wrong");

  a_push_address: assert property (@(posedge i_clock) disable iff (i_srst) // [RQ3]
    accept |=> (o_stack_data == $past(i_pc_next)))
    else $error("saved address is not the next instruction");

endmodule

// *** verif/mivu_cpu_model.sv ***
/*
  Far-side model of the CPU core: retires instructions and tracks the PC.
  Assumes the unit's acceptance outputs and stalls while i_busy is high.
*/
module mivu_cpu_model (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_slow,
  input  wire logic        i_busy,
  input  wire logic        i_pc_load,
  input  wire logic [11:0] i_pc_value,
  output logic             o_instr_done,
  output logic [11:0]      o_pc_next
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_r;
  // Slow mode retires one instruction in four cycles, so acceptance waits.
  assign o_instr_done = !i_busy && (cnt_r == 2'h0);
  always_ff @(posedge i_clock) begin
    if (i_srst || !i_slow)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  end
  always_ff @(posedge i_clock) begin
    if (i_srst)
      o_pc_next <= 12'h100;
    else if (i_pc_load)
      o_pc_next <= i_pc_value;
    else if (o_instr_done)
      o_pc_next <= o_pc_next + 12'h001;
  end
endmodule

// *** verif/mivu_top_tb.sv ***
/*
  Self-checking bench of the interrupt vector unit with a CPU core model.
  Assumes the package offsets and a read answer one cycle after the strobe.
*/
module mivu_top_tb
  import mivu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock, i_srst, i_mem_rd, i_mem_wr, i_slow, rd_seen;
  logic        i_keyline10_level, i_keygrp2_request, i_serial_request;
  logic        i_interrupt_flag, i_instr_done, o_irq_request;
  logic        o_stack_push, o_pc_load, o_busy, pushed;
  logic        o_heavy_load_mode, o_lcd_static_select, o_serial_clock_trigger;
  logic        o_tick_counter_clear, o_lap_counter_clear, hl;
  logic [2:0]  tr, tg;
  logic [11:0] i_mem_addr, i_pc_next, o_pc_value, o_stack_data, sd;
  logic [4:0]  ev;
  logic [3:0]  i_mem_wdata, o_mem_rdata, i_keygrp0_level, w;
  logic [3:0]  exp_q[$];
  int          num_errors, checked, seed, n;
  localparam logic [11:0] RW_ADDR [5] = '{ADDR_KEYGRP0_COMPARE,
    ADDR_KEYGRP0_ENABLE, ADDR_LOAD_LAP_ENABLE, ADDR_LCD_TICK_ENABLE,
    ADDR_KEY10_CONTROL};
  localparam logic [3:0]  RW_MASK [5] = '{4'hF, 4'hF, 4'hB, 4'hF, 4'h6};
  localparam logic [4:0]  SRC_EV [4] = '{5'h01, 5'h08, 5'h00, 5'h00};
  localparam logic [3:0]  VEC [4] = '{4'h4, 4'h8, 4'h2, 4'h1};

  mivu_top dut (.*, .i_fast_tick(ev[0]), .i_mid_tick(ev[1]),
    .i_slow_tick(ev[2]), .i_lap_tenth(ev[3]), .i_lap_second(ev[4]),
    .i_sub_bld_low(1'b0), .o_stack_data(o_stack_data),
    .o_heavy_load_mode(o_heavy_load_mode),
    .o_lcd_static_select(o_lcd_static_select),
    .o_serial_clock_trigger(o_serial_clock_trigger),
    .o_tick_counter_clear(o_tick_counter_clear),
    .o_lap_counter_clear(o_lap_counter_clear));
  mivu_cpu_model cpu (.i_clock(i_clock), .i_srst(i_srst), .i_slow(i_slow),
    .i_busy(o_busy), .i_pc_load(o_pc_load), .i_pc_value(o_pc_value),
    .o_instr_done(i_instr_done), .o_pc_next(i_pc_next));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [3:0] d);
    @(posedge i_clock);
    i_mem_addr <= a;
    i_mem_wdata <= d;
    i_mem_wr <= 1'b1;
    #1;
    tr = {a == ADDR_KEY10_CONTROL && d[3], a == ADDR_COUNTER_CLEAR && d[3],
          a == ADDR_COUNTER_CLEAR && d[1]};
    tg = {o_serial_clock_trigger, o_tick_counter_clear, o_lap_counter_clear};
    check({9'h0, tg}, {9'h0, tr});
    @(posedge i_clock);
    i_mem_wr <= 1'b0;
  endtask

  // A flag event that lands in the very cycle of a clearing read.
  task automatic pulse_rd(input logic [11:0] a, input logic [3:0] e,
                          input logic [4:0] p);
    fork
      bus_rd(a, e);
      begin
        @(posedge i_clock);
        ev <= p;
        @(posedge i_clock);
        ev <= 5'h00;
      end
    join
  endtask

  task automatic bus_rd(input logic [11:0] a, input logic [3:0] e);
    @(posedge i_clock);
    i_mem_addr <= a;
    i_mem_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clock);
    i_mem_rd <= 1'b0;
  endtask

  // ********************************************************************
  // Read data is compared against the oldest note one cycle after a read.
  // ********************************************************************
  always @(posedge i_clock) begin
    if (rd_seen)
      check({8'h0, o_mem_rdata}, {8'h0, exp_q.pop_front()});
    rd_seen <= i_mem_rd;
  end

  task automatic accept(input logic [3:0] v);
    n = 0;
    pushed = 1'b0;
    @(posedge i_clock);
    i_interrupt_flag <= 1'b1;
    #1;
    repeat (80) begin
      sd = i_pc_next;
      @(posedge i_clock);
      #1;
      if (o_stack_push === 1'b1)
        check(o_stack_data, sd);
      pushed = pushed | o_stack_push;
      if (o_busy === 1'b1)
        n++;
      if (o_pc_load === 1'b1)
        break;
    end
    if (o_pc_load !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    check(o_pc_value, {4'h1, 4'h0, v});
    check({11'h0, pushed}, 12'h001);
    check(12'(n), 12'h00C);
    @(posedge i_clock);
    i_interrupt_flag <= 1'b0;
  endtask

  initial begin
    seed = 92227;
    {i_mem_rd, i_mem_wr, i_slow, rd_seen, i_keyline10_level} = '0;
    {i_keygrp2_request, i_serial_request, i_interrupt_flag, ev} = '0;
    {i_mem_addr, i_mem_wdata, i_keygrp0_level} = '0;
    i_srst = 1'b1;
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    #1;
    check({11'h0, o_pc_load}, 12'h001);
    check(o_pc_value, 12'h100);
    for (int k = 0; k < 5; k++) begin
      bus_rd(RW_ADDR[k], 4'h0);
      w = 4'($random(seed));
      bus_wr(RW_ADDR[k], w);
      bus_rd(RW_ADDR[k], w & RW_MASK[k]);
      hl = k[0] ? o_lcd_static_select : o_heavy_load_mode;
      if (k == 2 || k == 3)
        check({11'h0, hl}, {11'h0, w[3]});
      bus_wr(RW_ADDR[k], 4'h0);
    end
    bus_wr(ADDR_COUNTER_CLEAR, 4'hA);
    bus_rd(ADDR_COUNTER_CLEAR, 4'h0);
    pulse_rd(ADDR_TIMER_FLAGS, 4'h0, 5'h07);
    #1;
    check({11'h0, o_irq_request}, 12'h000);
    bus_rd(ADDR_TIMER_FLAGS, 4'h7);
    pulse_rd(ADDR_TIMER_FLAGS, 4'h0, 5'h18);
    bus_rd(ADDR_KEY_LAP_FLAGS, 4'h3);
    bus_wr(ADDR_KEYGRP0_ENABLE, 4'hF);
    w = 4'($random(seed)) | 4'h1;
    i_keygrp0_level <= w;
    bus_rd(ADDR_KEYGRP0_LEVELS, w);
    i_keygrp0_level <= 4'h0;
    bus_rd(ADDR_KEY_LAP_FLAGS, 4'h4);
    bus_wr(ADDR_KEY10_CONTROL, 4'hC);
    bus_rd(ADDR_KEY_LAP_FLAGS, 4'h0);
    i_keyline10_level <= 1'b1;
    bus_rd(ADDR_KEY10_CONTROL, 4'h5);
    bus_rd(ADDR_KEY_LAP_FLAGS, 4'h8);
    bus_wr(ADDR_LCD_TICK_ENABLE, 4'h1);
    bus_wr(ADDR_LOAD_LAP_ENABLE, 4'h1);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      i_slow <= k[0];
      ev <= SRC_EV[k];
      i_keygrp2_request <= (k == 2);
      i_serial_request <= (k == 3);
      @(posedge i_clock);
      ev <= 5'h00;
      #1;
      check({11'h0, o_irq_request}, 12'h001);
      accept(VEC[k]);
      bus_rd(ADDR_TIMER_FLAGS, {3'h0, k == 0});
      bus_rd(ADDR_KEY_LAP_FLAGS, {3'h0, k == 1});
      i_keygrp2_request <= 1'b0;
      i_serial_request <= 1'b0;
      @(posedge i_clock);
      #1;
      check({11'h0, o_irq_request}, 12'h000);
    end
    repeat (2) @(posedge i_clock);
    stop_test();
  end
endmodule
